// ==== tbrw_defs.svh ====
// constants for the tag block read/write command handler
`ifndef TBRW_DEFS_SVH
`define TBRW_DEFS_SVH

`define TBRW_CMD_READ_MULTI   6'h12
`define TBRW_CMD_WRITE_SINGLE 6'h14
`define TBRW_UID_BITS         48
`define TBRW_BUF_BITS         128
`define TBRW_LEN_READ         8'h1B
`define TBRW_LEN_READ_UID     8'h4B
`define TBRW_LEN_WRITE        8'h33
`define TBRW_LEN_WRITE_UID    8'h63
`define TBRW_LEN_INVENTORY    8'h21
`define TBRW_MAX_BLOCK        9'h0FF
`define TBRW_ERR_CODE         3'h7
`define TBRW_CLK_MHZ          40
`define TBRW_PROG_TIME_US     5000
`define TBRW_REG_CTRL         8'h00
`define TBRW_REG_UID_LO       8'h04
`define TBRW_REG_UID_HI       8'h08
`define TBRW_REG_STATUS       8'h0C
`define TBRW_CTRL_RESET       32'h0000_0000
`define TBRW_CTRL_ADV_BIT     0
`define TBRW_CTRL_SEL_BIT     1
`define TBRW_RESP_OKAY        2'h0
`define TBRW_RESP_SLVERR      2'h2

`endif

// ==== tbrw_pkg.sv ====
// types for the tag block read/write command handler
`default_nettype none
package tbrw_pkg;
  typedef enum logic [3:0] {
    TBRW_IDLE   = 4'h0,
    TBRW_UID    = 4'h1,
    TBRW_FLAG   = 4'h3,
    TBRW_RDADDR = 4'h2,
    TBRW_RDLOAD = 4'h6,
    TBRW_PROG   = 4'h7,
    TBRW_ERR    = 4'h5
  } tbrw_state_t;

  typedef struct packed {
    logic addrSlotCnt;
    logic selRfu;
    logic crcReq;
    logic inventory;
    logic protoExt;
  } tbrw_flags_t;
endpackage : tbrw_pkg
`default_nettype wire

// ==== tbrw_mem_if.sv ====
// memory port between handler and block store
`default_nettype none
interface tbrw_mem_if;
  logic [7:0]  addr;
  logic        wrEn;
  logic [31:0] wrData;
  logic [31:0] rdData;
  modport ctrl (output addr, output wrEn, output wrData, input rdData);
  modport mem  (input addr, input wrEn, input wrData, output rdData);
endinterface : tbrw_mem_if
`default_nettype wire

// ==== tbrw_mem.sv ====
// 256 x 32 user block store with registered read
`default_nettype none
module tbrw_mem (
  // clock
  input wire logic ref_clk,
  // port
  tbrw_mem_if.mem  port
);
  logic [31:0] store [0:255];
  logic [31:0] rdData_reg;

  always_ff @(posedge ref_clk) begin
    if (port.wrEn) begin
      store[port.addr] <= port.wrData;
    end
    rdData_reg <= store[port.addr];
  end

  assign port.rdData = rdData_reg;
endmodule : tbrw_mem
`default_nettype wire

// ==== tbrw_top.sv ====
// tag block read/write command handler with AXI4-Lite control
// Functional notes
// - error-free read multiple (12h) fetches every requested block and returns it
// - block index is 8 bits, blocks 0 to 255, first-block field picks start
// - count field is blocks minus one: 0 reads one, 6 reads seven
// - read reply: error bit, 32 bits per block in order, optional CRC
// - successful replies lead with error bit 0; inventory replies send the UID part before it
// - basic variant: unaddressed or UID forms, ready state only
// - advanced adds select-flag form without UID, selected device only
// - inventory read carries 6-bit mask length and mask before block fields
// - any error during inventory read gives no reply at all
// - inventory reply first sends 48 minus n UID bits, dual pattern coded
// - after the UID part the rest is Manchester coded
// - error-free write single (14h) stores 32 bits into the block and reports
// - write request: flags, command, optional UID, index, 32 data bits, CRC
// - write reply: error bit only plus optional CRC, no data
// - address and select flags choose which devices answer
// - CRC appended only when the request asks for it
// - failed command answers error bit set then code 111, optional CRC
// - slot-count flag: 0 means 16 slots, 1 means a single slot
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`default_nettype none
`include "tbrw_defs.svh"
module tbrw_top #(
  parameter int PROG_CYCLES = `TBRW_PROG_TIME_US * `TBRW_CLK_MHZ
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // request bits from the demodulator
  input  wire logic        rxValid,
  input  wire logic        rxBit,
  input  wire logic        rxEnd,
  input  wire logic        rxCrcOk,
  // reply bits to the line coder
  output var  logic        txValid,
  output var  logic        txBit,
  output var  logic        txDual,
  output var  logic        txLast,
  output var  logic        txCrc,
  output var  logic        txSingleSlot,
  input  wire logic        txReady,
  // axi4-lite write channels
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read channels
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  tbrw_mem_if memBus ();

  tbrw_mem u_mem (
    .ref_clk (ref_clk),
    .port    (memBus)
  );

  // register index decode, shared by read and write paths
  function automatic logic [2:0] regSel(input logic [7:0] a);
    case (a)
      `TBRW_REG_CTRL:   regSel = 3'h1;
      `TBRW_REG_UID_LO: regSel = 3'h2;
      `TBRW_REG_UID_HI: regSel = 3'h3;
      `TBRW_REG_STATUS: regSel = 3'h4;
      default:          regSel = 3'h0;
    endcase
  endfunction : regSel

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] val,
                                            input logic [3:0] strb);
    mergeStrb = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        mergeStrb[i*8 +: 8] = val[i*8 +: 8];
      end
    end
  endfunction : mergeStrb

  // software state
  logic [31:0] ctrl_reg;
  logic [47:0] uid_reg;
  logic [5:0]  lastCmd_reg;
  logic        lastErr_reg;
  logic [15:0] reqCount_reg;

  // receive side
  logic [`TBRW_BUF_BITS-1:0] rxBuf_reg;
  logic [7:0]                rxCnt_reg;
  logic                      rxOvf_reg;

  // command state
  tbrw_pkg::tbrw_state_t state_reg;
  tbrw_pkg::tbrw_state_t state_next;
  logic [7:0]  blk_reg;
  logic [7:0]  blkLeft_reg;
  logic [5:0]  uidLen_reg;
  logic        isWrite_reg;
  logic [19:0] progCnt_reg;
  logic        memWr_reg;
  logic [31:0] memData_reg;

  // bit sender
  logic [47:0] txSh_reg;
  logic [5:0]  txCnt_reg;
  logic        txFin_reg;
  logic        txDual_reg;
  logic        txLast_reg;
  logic        txCrc_reg;
  logic        txSlot_reg;

  // frame decode
  wire logic [7:0]   shAmt       = 8'(8'd128 - rxCnt_reg);
  wire logic [127:0] aligned     = rxBuf_reg << shAmt;
  wire tbrw_pkg::tbrw_flags_t flags = aligned[127:123];
  wire logic [5:0]   cmd         = aligned[122:117];
  wire logic [5:0]   maskLen     = aligned[116:111];
  wire logic [47:0]  maskField   = rxBuf_reg[63:16];
  wire logic [47:0]  maskOnes    = ~(48'hFFFF_FFFF_FFFF << maskLen);
  wire logic         advanced    = ctrl_reg[`TBRW_CTRL_ADV_BIT];
  wire logic         selected    = ctrl_reg[`TBRW_CTRL_SEL_BIT];
  wire logic         isRead      = (cmd == `TBRW_CMD_READ_MULTI);
  wire logic         isWrite     = (cmd == `TBRW_CMD_WRITE_SINGLE);
  wire logic         isInventory = flags.inventory;
  wire logic         withUid     = flags.addrSlotCnt & ~flags.selRfu;
  wire logic [47:0]  uidInReq    = isWrite ? rxBuf_reg[87:40] : rxBuf_reg[63:16];
  wire logic [7:0]   reqBlk      = isWrite ? rxBuf_reg[39:32] : rxBuf_reg[15:8];
  wire logic [7:0]   reqNum      = rxBuf_reg[7:0];
  wire logic [8:0]   lastBlk     = {1'b0, reqBlk} + {1'b0, reqNum};
  wire logic [7:0]   lenPlain    = isWrite ? (withUid ? `TBRW_LEN_WRITE_UID : `TBRW_LEN_WRITE)
                                           : (withUid ? `TBRW_LEN_READ_UID : `TBRW_LEN_READ);
  wire logic [7:0]   lenInventory = 8'(`TBRW_LEN_INVENTORY + {2'h0, maskLen});
  wire logic         frameBad    = ~rxCrcOk | rxOvf_reg | flags.protoExt;

  // plain forms answer in ready state, UID form needs a match, select form needs selection
  wire logic addrPlain  = ~flags.addrSlotCnt & ~flags.selRfu & ~selected;
  wire logic addrUid    = withUid & ~selected & (uidInReq == uid_reg);
  wire logic addrSel    = ~flags.addrSlotCnt & flags.selRfu & advanced & selected;
  wire logic addressed  = ~isInventory & (isRead | isWrite) &
                          (addrPlain | addrUid | addrSel);
  wire logic plainErr   = frameBad | (rxCnt_reg != lenPlain) | (isRead & lastBlk > `TBRW_MAX_BLOCK);

  // inventory read: any fault means silence
  wire logic maskMatch  = ((maskField ^ uid_reg) & maskOnes) == 48'h0;
  wire logic inventoryOk = isInventory & isRead & advanced & ~selected & ~frameBad &
                           ~flags.selRfu & (maskLen <= 6'd48) & (rxCnt_reg == lenInventory) &
                           maskMatch & (lastBlk <= `TBRW_MAX_BLOCK);

  // sender free when idle or its final bit is being taken
  wire logic txTake    = txValid & txReady;
  wire logic sendFree  = (txCnt_reg == 6'h0) | ((txCnt_reg == 6'h1) & txTake);
  logic        load;
  logic [47:0] loadVal;
  logic [5:0]  loadLen;
  logic        loadDual;
  logic        loadFin;

  always_comb begin
    state_next = state_reg;
    load       = 1'b0;
    loadVal    = 48'h0;
    loadLen    = 6'h0;
    loadDual   = 1'b0;
    loadFin    = 1'b0;
    case (state_reg)
      tbrw_pkg::TBRW_IDLE: begin
        if (rxEnd) begin
          if (inventoryOk) begin
            state_next = tbrw_pkg::TBRW_UID;
          end else if (addressed & plainErr) begin
            state_next = tbrw_pkg::TBRW_ERR;
          end else if (addressed & isWrite) begin
            state_next = tbrw_pkg::TBRW_PROG;
          end else if (addressed) begin
            state_next = tbrw_pkg::TBRW_FLAG;
          end
        end
      end
      tbrw_pkg::TBRW_UID: begin
        if (uidLen_reg == 6'h0) begin
          state_next = tbrw_pkg::TBRW_FLAG;
        end else if (sendFree) begin
          load       = 1'b1;
          loadVal    = uid_reg;
          loadLen    = uidLen_reg;
          loadDual   = 1'b1;
          state_next = tbrw_pkg::TBRW_FLAG;
        end
      end
      tbrw_pkg::TBRW_FLAG: begin
        if (sendFree) begin
          load       = 1'b1;
          loadVal    = 48'h0;
          loadLen    = 6'h1;
          loadFin    = isWrite_reg;
          state_next = isWrite_reg ? tbrw_pkg::TBRW_IDLE : tbrw_pkg::TBRW_RDADDR;
        end
      end
      tbrw_pkg::TBRW_RDADDR: begin
        state_next = tbrw_pkg::TBRW_RDLOAD;
      end
      tbrw_pkg::TBRW_RDLOAD: begin
        if (sendFree) begin
          load       = 1'b1;
          loadVal    = {memBus.rdData, 16'h0};
          loadLen    = 6'd32;
          loadFin    = (blkLeft_reg == 8'h0);
          state_next = loadFin ? tbrw_pkg::TBRW_IDLE : tbrw_pkg::TBRW_RDADDR;
        end
      end
      tbrw_pkg::TBRW_PROG: begin
        if (progCnt_reg == 20'h0) begin
          state_next = tbrw_pkg::TBRW_FLAG;
        end
      end
      tbrw_pkg::TBRW_ERR: begin
        if (sendFree) begin
          load       = 1'b1;
          loadVal    = {1'b1, `TBRW_ERR_CODE, 44'h0};
          loadLen    = 6'h4;
          loadFin    = 1'b1;
          state_next = tbrw_pkg::TBRW_IDLE;
        end
      end
      default: begin
        state_next = tbrw_pkg::TBRW_IDLE;
      end
    endcase
  end

  wire logic accept = (state_reg == tbrw_pkg::TBRW_IDLE) & rxEnd;

  // command tracking
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg    <= tbrw_pkg::TBRW_IDLE;
      blk_reg      <= 8'h0;
      blkLeft_reg  <= 8'h0;
      uidLen_reg   <= 6'h0;
      isWrite_reg  <= 1'b0;
      progCnt_reg  <= 20'h0;
      memWr_reg    <= 1'b0;
      memData_reg  <= 32'h0;
      txCrc_reg    <= 1'b0;
      txSlot_reg   <= 1'b0;
      lastCmd_reg  <= 6'h0;
      lastErr_reg  <= 1'b0;
      reqCount_reg <= 16'h0;
    end else begin
      state_reg <= state_next;
      memWr_reg <= accept & addressed & isWrite & ~plainErr;
      if (accept & (inventoryOk | addressed)) begin
        blk_reg      <= reqBlk;
        blkLeft_reg  <= reqNum;
        uidLen_reg   <= 6'(6'd48 - maskLen);
        isWrite_reg  <= isWrite;
        memData_reg  <= rxBuf_reg[31:0];
        progCnt_reg  <= 20'(PROG_CYCLES);
        txCrc_reg    <= flags.crcReq;
        txSlot_reg   <= isInventory & flags.addrSlotCnt;
        lastCmd_reg  <= cmd;
        lastErr_reg  <= ~inventoryOk & plainErr;
        reqCount_reg <= reqCount_reg + 16'h1;
      end
      if ((state_reg == tbrw_pkg::TBRW_PROG) && (progCnt_reg != 20'h0)) begin
        progCnt_reg <= progCnt_reg - 20'h1;
      end
      if ((state_reg == tbrw_pkg::TBRW_RDLOAD) && load) begin
        blk_reg     <= blk_reg + 8'h1;
        blkLeft_reg <= blkLeft_reg - 8'h1;
      end
    end
  end

  assign memBus.addr   = blk_reg;
  assign memBus.wrEn   = memWr_reg;
  assign memBus.wrData = memData_reg;

  // receive shift register; bits arriving while busy are dropped
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBuf_reg <= '0;
      rxCnt_reg <= 8'h0;
      rxOvf_reg <= 1'b0;
    end else if (rxEnd) begin
      rxCnt_reg <= 8'h0;
      rxOvf_reg <= 1'b0;
    end else if (rxValid && (state_reg == tbrw_pkg::TBRW_IDLE)) begin
      rxBuf_reg <= {rxBuf_reg[`TBRW_BUF_BITS-2:0], rxBit};
      if (rxCnt_reg == 8'd128) begin
        rxOvf_reg <= 1'b1;
      end else begin
        rxCnt_reg <= rxCnt_reg + 8'h1;
      end
    end
  end

  // bit sender, MSB first
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      txSh_reg   <= 48'h0;
      txCnt_reg  <= 6'h0;
      txFin_reg  <= 1'b0;
      txDual_reg <= 1'b0;
      txLast_reg <= 1'b0;
    end else if (load) begin
      txSh_reg   <= loadVal;
      txCnt_reg  <= loadLen;
      txFin_reg  <= loadFin;
      txDual_reg <= loadDual;
      txLast_reg <= loadFin & (loadLen == 6'h1);
    end else if (txTake) begin
      txSh_reg   <= {txSh_reg[46:0], 1'b0};
      txCnt_reg  <= txCnt_reg - 6'h1;
      txLast_reg <= txFin_reg & (txCnt_reg == 6'h2);
    end
  end

  assign txValid      = (txCnt_reg != 6'h0);
  assign txBit        = txSh_reg[47];
  assign txDual       = txDual_reg;
  assign txLast       = txLast_reg;
  assign txCrc        = txCrc_reg;
  assign txSingleSlot = txSlot_reg;

  // axi4-lite slave: address and data taken in either order
  logic        awHave_reg;
  logic        wHave_reg;
  logic [7:0]  awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0]  wStrb_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;

  wire logic       awTake   = s_axi_awvalid & awready_reg;
  wire logic       wTake    = s_axi_wvalid & wready_reg;
  wire logic       doWrite  = awHave_reg & wHave_reg & ~bvalid_reg;
  wire logic       bDone    = bvalid_reg & s_axi_bready;
  wire logic       awHaveNx = (awHave_reg | awTake) & ~doWrite;
  wire logic       wHaveNx  = (wHave_reg | wTake) & ~doWrite;
  wire logic       bvalidNx = doWrite | (bvalid_reg & ~bDone);
  wire logic [2:0] wSel     = regSel(awAddr_reg);
  wire logic       arTake   = s_axi_arvalid & arready_reg;
  wire logic       rDone    = rvalid_reg & s_axi_rready;
  wire logic       rvalidNx = arTake | (rvalid_reg & ~rDone);
  wire logic [2:0] rSel     = regSel(s_axi_araddr);
  wire logic [31:0] status  = {reqCount_reg, 6'h0, txSlot_reg, lastErr_reg,
                               lastCmd_reg, (state_reg != tbrw_pkg::TBRW_IDLE), txValid};
  wire logic [31:0] rMux    = (rSel == 3'h1) ? ctrl_reg :
                              (rSel == 3'h2) ? uid_reg[31:0] :
                              (rSel == 3'h3) ? {16'h0, uid_reg[47:32]} :
                              (rSel == 3'h4) ? status : 32'h0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awHave_reg  <= 1'b0;
      wHave_reg   <= 1'b0;
      awAddr_reg  <= 8'h0;
      wData_reg   <= 32'h0;
      wStrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `TBRW_RESP_OKAY;
      ctrl_reg    <= `TBRW_CTRL_RESET;
      uid_reg     <= 48'h0;
    end else begin
      awHave_reg  <= awHaveNx;
      wHave_reg   <= wHaveNx;
      awready_reg <= ~awHaveNx & ~bvalidNx;
      wready_reg  <= ~wHaveNx & ~bvalidNx;
      bvalid_reg  <= bvalidNx;
      if (awTake) begin
        awAddr_reg <= s_axi_awaddr;
      end
      if (wTake) begin
        wData_reg <= s_axi_wdata;
        wStrb_reg <= s_axi_wstrb;
      end
      if (doWrite) begin
        bresp_reg <= ((wSel == 3'h0) || (awAddr_reg[1:0] != 2'h0)) ? `TBRW_RESP_SLVERR
                                                                  : `TBRW_RESP_OKAY;
        if (wSel == 3'h1) begin
          ctrl_reg <= mergeStrb(ctrl_reg, wData_reg, wStrb_reg) & 32'h0000_0003;
        end
        if (wSel == 3'h2) begin
          uid_reg[31:0] <= mergeStrb(uid_reg[31:0], wData_reg, wStrb_reg);
        end
        if (wSel == 3'h3) begin
          uid_reg[47:32] <= 16'(mergeStrb({16'h0, uid_reg[47:32]}, wData_reg, wStrb_reg));
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= `TBRW_RESP_OKAY;
    end else begin
      arready_reg <= ~rvalidNx;
      rvalid_reg  <= rvalidNx;
      if (arTake) begin
        rdata_reg <= rMux;
        rresp_reg <= (rSel == 3'h0) ? `TBRW_RESP_SLVERR : `TBRW_RESP_OKAY;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
endmodule : tbrw_top
`default_nettype wire

// ==== tbrw_top_asserts.sv ====
// port-level assertion checker for the tag block read/write handler
`default_nettype none
module tbrw_top_asserts (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // link
  input wire logic        rxEnd,
  input wire logic        txValid,
  input wire logic        txBit,
  input wire logic        txDual,
  input wire logic        txLast,
  input wire logic        txReady,
  // register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_lastValid; txLast |-> txValid; endproperty
  a_lastValid: assert property (p_lastValid) else $error("last flag without valid");
  property p_txHold; txValid && !txReady |=> txValid && $stable({txBit, txDual, txLast}); endproperty
  a_txHold: assert property (p_txHold) else $error("reply bit changed before taken");
  property p_noEarly; rxEnd && !txValid |=> !txValid; endproperty
  a_noEarly: assert property (p_noEarly) else $error("reply started too early");
  property p_manchTail; txValid && txReady && !txDual && !txLast |=> !txDual; endproperty
  a_manchTail: assert property (p_manchTail) else $error("dual coding after manchester");
  property p_bHold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bHold: assert property (p_bHold) else $error("write response dropped");
  property p_rAns; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rAns: assert property (p_rAns) else $error("read answer late");
  property p_awBusy; s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2]; endproperty
  a_awBusy: assert property (p_awBusy) else $error("write address reopened early");
  property p_errZero; s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0; endproperty
  a_errZero: assert property (p_errZero) else $error("error read with data");
endmodule : tbrw_top_asserts
bind tbrw_top tbrw_top_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .rxEnd(rxEnd),
  .txValid(txValid), .txBit(txBit), .txDual(txDual), .txLast(txLast), .txReady(txReady),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// ==== tbrw_reader.sv ====
// behavioural reader model: sends request bits, collects reply bits
`default_nettype none
module tbrw_reader (
  // clock
  input wire logic  ref_clk,
  // request side
  output var logic  rxValid,
  output var logic  rxBit,
  output var logic  rxEnd,
  output var logic  rxCrcOk,
  // reply side
  input wire logic  txValid,
  input wire logic  txBit,
  input wire logic  txDual,
  input wire logic  txLast,
  output var logic  txReady
);
  timeunit 1ns;
  timeprecision 1ps;
  logic q[$];
  int   dual;
  int   lat;
  logic done;
  logic slow;
  initial begin
    rxValid = 1'b0;
    rxBit = 1'b0;
    rxEnd = 1'b0;
    rxCrcOk = 1'b1;
    txReady = 1'b1;
    done = 1'b0;
    slow = 1'b0;
    dual = 0;
    lat = 0;
  end
  // msb first, fields in request order, crc reported as a flag only
  task automatic send(input logic [127:0] v, input int n, input logic ok);
    q.delete();
    dual = 0;
    done <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      rxValid <= 1'b1;
      rxBit <= v[i];
      @(posedge ref_clk);
    end
    rxValid <= 1'b0;
    rxBit <= ~rxBit;
    rxEnd <= 1'b1;
    rxCrcOk <= ok;
    @(posedge ref_clk);
    rxEnd <= 1'b0;
  endtask : send
  // slow mode stalls every other cycle
  always @(posedge ref_clk) begin
    txReady <= slow ? ~txReady : 1'b1;
    if (rxEnd) lat <= 0;
    else if (!txValid && q.size() == 0) lat <= lat + 1;
    if (txValid && txReady) begin
      q.push_back(txBit);
      dual = dual + int'(txDual);
      if (txLast) done <= 1'b1;
    end
  end
endmodule : tbrw_reader
`default_nettype wire

// ==== tbrw_top_tb.sv ====
// self-checking bench for the tag block read/write handler
`default_nettype none
module tbrw_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [47:0] UID = 48'h3C5A_9E17_42B6;
  localparam logic [31:0] D5 = 32'hA5C3_1E0F;
  localparam logic [31:0] D6 = 32'h5A3C_E1F0;
  localparam logic [31:0] DF = 32'h0F1E_2D3C;
  logic ref_clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  wire logic rxValid, rxBit, rxEnd, rxCrcOk, txReady, txValid, txBit, txDual, txLast;
  wire logic txCrc, txSlot, awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  int errorCnt, totalChecks;
  tbrw_top #(.PROG_CYCLES(8)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .rxValid(rxValid),
    .rxBit(rxBit), .rxEnd(rxEnd), .rxCrcOk(rxCrcOk), .txValid(txValid), .txBit(txBit),
    .txDual(txDual), .txLast(txLast), .txCrc(txCrc), .txSingleSlot(txSlot),
    .txReady(txReady), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tbrw_reader rdr (.ref_clk(ref_clk), .rxValid(rxValid), .rxBit(rxBit), .rxEnd(rxEnd),
    .rxCrcOk(rxCrcOk), .txValid(txValid), .txBit(txBit), .txDual(txDual), .txLast(txLast),
    .txReady(txReady));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic conclude;
    if (errorCnt == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    totalChecks++;
    if (g !== e) begin
      errorCnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic tmo(input logic hit);
    if (hit) begin
      errorCnt++;
      conclude();
    end
  endtask : tmo
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    k = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 50);
    // bready stays high: back-to-back writes never reassign it in one step
    tmo(k >= 50);
    chk(bresp, r);
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    int k;
    k = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 50);
    rready <= 1'b0;
    tmo(k >= 50);
    chk(rdata, e);
    chk(rresp, r);
  endtask : axr
  // n of zero means the tag must stay silent
  task automatic rep(input logic [127:0] e, input int n, input int d);
    int k;
    k = 0;
    while (!rdr.done && k < (n != 0 ? 3000 : 300)) begin
      @(posedge ref_clk);
      k++;
    end
    tmo(n != 0 && k >= 3000);
    chk(rdr.q.size(), n);
    for (int i = 0; i < n; i++) chk(rdr.q[i], e[n-1-i]);
    chk(rdr.dual, d);
    repeat (4) @(posedge ref_clk);
  endtask : rep
  initial begin
    rst_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    errorCnt = 0;
    totalChecks = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    axr(8'h00, 32'h0, 2'h0);
    axw(8'h00, 32'hFFFF_FFFF, 2'h0);
    axr(8'h00, 32'h3, 2'h0);
    axw(8'h04, UID[31:0], 2'h0);
    axw(8'h08, {16'hFFFF, UID[47:32]}, 2'h0);
    axr(8'h08, {16'h0, UID[47:32]}, 2'h0);
    axw(8'h10, 32'h1234_5678, 2'h2);
    axr(8'h10, 32'h0, 2'h2);
    axw(8'h00, 32'h1, 2'h0);
    rdr.send({5'b00100, 6'h14, 8'h05, D5}, 51, 1'b1);
    rep(128'h0, 1, 0);
    chk(rdr.lat >= 8, 1);
    chk(txCrc, 1);
    rdr.send({5'b00000, 6'h14, 8'h06, D6}, 51, 1'b1);
    rep(128'h0, 1, 0);
    rdr.send({5'b10100, 6'h14, UID, 8'hFF, DF}, 99, 1'b1);
    rep(128'h0, 1, 0);
    rdr.slow = 1'b1;
    rdr.send({5'b00000, 6'h12, 8'h05, 8'h00}, 27, 1'b1);
    rep({1'b0, D5}, 33, 0);
    chk(txCrc, 0);
    rdr.send({5'b10000, 6'h12, UID, 8'h05, 8'h01}, 75, 1'b1);
    rep({1'b0, D5, D6}, 65, 0);
    rdr.send({5'b00000, 6'h12, 8'hFF, 8'h00}, 27, 1'b1);
    rep({1'b0, DF}, 33, 0);
    rdr.send({5'b00000, 6'h12, 8'hFF, 8'h01}, 27, 1'b1);
    rep(128'hF, 4, 0);
    rdr.send({5'b00000, 6'h12, 8'h05, 8'h00}, 27, 1'b0);
    rep(128'hF, 4, 0);
    rdr.send({5'b00000, 6'h13, 8'h05, 8'h00}, 27, 1'b1);
    rep(128'h0, 0, 0);
    rdr.send({5'b11000, 6'h12, 8'h05, 8'h00}, 27, 1'b1);
    rep(128'h0, 0, 0);
    rdr.send({5'b10000, 6'h12, ~UID, 8'h05, 8'h00}, 75, 1'b1);
    rep(128'h0, 0, 0);
    rdr.send({5'b10010, 6'h12, 6'd8, UID[7:0], 8'h05, 8'h00}, 41, 1'b1);
    rep({UID[47:8], 1'b0, D5}, 73, 40);
    chk(txSlot, 1);
    rdr.send({5'b00010, 6'h12, 6'd8, ~UID[7:0], 8'h05, 8'h00}, 41, 1'b1);
    rep(128'h0, 0, 0);
    axw(8'h00, 32'h3, 2'h0);
    rdr.send({5'b01000, 6'h12, 8'h06, 8'h00}, 27, 1'b1);
    rep({1'b0, D6}, 33, 0);
    rdr.send({5'b00000, 6'h12, 8'h06, 8'h00}, 27, 1'b1);
    rep(128'h0, 0, 0);
    // ten accepted requests, last one a select-form read, no error, no single slot
    axr(8'h0C, 32'h000A_0048, 2'h0);
    conclude();
  end
endmodule : tbrw_top_tb
`default_nettype wire
